// file: rtl/sfp_core.sv
// fetch, decode, scoreboard and issue pipeline of the 32-bit load/store core
module sfp_core (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  output logic fch_req_o,
  output logic [31:0] fch_addr_o,
  input wire logic fch_gnt_i,
  input wire logic fch_rvalid_i,
  input wire logic [31:0] fch_rdata_i,
  output logic dmem_valid_o,
  output sfp_pkg::sfp_dreq_type dmem_req_o,
  input wire logic dmem_ready_i,
  input wire logic drsp_valid_i,
  input wire sfp_pkg::sfp_drsp_type drsp_i,
  output logic wb_valid_o,
  output sfp_pkg::sfp_wb_type wb_o,
  output logic [31:0] pc_o
);
  localparam int LO = sfp_pkg::LINE_OFS;

  typedef enum logic [1:0] {FB_IDLE, FB_REQ, FB_DATA} sfp_fb_type;
  typedef enum logic {ISS_RUN, ISS_FLUSH} sfp_iss_type;

  // fetch state
  sfp_fb_type fb_state;
  sfp_fb_type next_fb_state;
  logic [31-LO:0] fb_line;
  logic [31-LO:0] next_fb_line;
  logic [sfp_pkg::BEAT_W-1:0] fb_beat;
  logic [sfp_pkg::BEAT_W-1:0] next_fb_beat;
  logic fill_v;
  logic fwd;
  logic hit;
  logic pf_hit;
  logic [31:0] c_word;
  logic [31:0] pf_addr;

  // issue state
  logic [31:0] pc;
  logic [31:0] next_pc;
  sfp_iss_type iss;
  sfp_iss_type next_iss;
  logic [3:0] fl_idx;
  logic [3:0] next_fl_idx;
  logic [4:0] fl_reg;
  logic [sfp_pkg::NREG-1:0] sb;
  logic [sfp_pkg::NREG-1:0] next_sb;
  logic [1:0] ld_cnt;
  logic [1:0] next_ld_cnt;
  logic ld_inc;
  logic cc;
  logic next_cc;
  logic w_valid;
  logic next_w_valid;
  sfp_pkg::sfp_wb_type w;
  sfp_pkg::sfp_wb_type next_w;
  logic w_cmp;
  logic next_w_cmp;
  logic w_eq;
  logic next_w_eq;
  logic dq_valid;
  logic next_dq_valid;
  sfp_pkg::sfp_dreq_type dq;
  sfp_pkg::sfp_dreq_type next_dq;

  // decode and operand signals
  logic [31:0] ins;
  logic ins_ok;
  sfp_pkg::sfp_dec_type d;
  logic [31:0] a;
  logic [31:0] b;
  logic [31:0] c;
  logic [31:0] ea;
  logic [31:0] res;
  logic is_ld;
  logic is_dm;
  logic use_rs2;
  logic haz;
  logic res_stall;
  logic dq_free;
  logic issue;

  logic [31:0] rf [sfp_pkg::NREG];

  // operand read with bypass from the write-back stage
  function automatic logic [31:0] opnd(input logic [4:0] r);
    return (w_valid && w.dst == r) ? w.data : rf[r];
  endfunction

  // split a word into fields; immediates are per format
  function automatic sfp_pkg::sfp_dec_type sfp_decode(input logic [31:0] i);
    sfp_pkg::sfp_dec_type r;
    r.op = i[sfp_pkg::OP_POS +: 8];
    r.fmt = sfp_pkg::sfp_fmt(r.op);
    r.rd = i[sfp_pkg::RD_POS +: 5];
    r.rs1 = i[sfp_pkg::RS1_POS +: 5];
    r.rs2 = i[4:0];
    r.lit = i[sfp_pkg::LIT_POS] && (r.fmt == sfp_pkg::FMT_REG);
    r.scale = i[sfp_pkg::SCALE_POS +: 3];
    case (r.fmt)
      sfp_pkg::FMT_CTRL: r.imm = {{6{i[23]}}, i[23:0], 2'h0};
      sfp_pkg::FMT_COBR: r.imm = {{17{i[12]}}, i[12:0], 2'h0};
      sfp_pkg::FMT_MEMA: r.imm = {20'h0, i[11:0]};
      default: r.imm = 32'h0;
    endcase
    return r;
  endfunction

  sfp_icache #(
    .LINES(sfp_pkg::CACHE_LINES),
    .WORDS(sfp_pkg::LINE_WORDS)
  ) u_icache (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .rd_addr_i(pc),
    .rd_hit_o(hit),
    .rd_word_o(c_word),
    .probe_addr_i(pf_addr),
    .probe_hit_o(pf_hit),
    .fill_valid_i(fill_v),
    .fill_addr_i({fb_line, fb_beat, 2'h0}),
    .fill_data_i(fch_rdata_i),
    .fill_first_i(fb_beat == '0),
    .fill_last_i(fb_beat == sfp_pkg::LAST_BEAT)
  );

  // burst fill and same-cycle forward to decode
  assign pf_addr = {pc[31:LO] + 1'b1, {LO{1'b0}}};
  assign fill_v = (fb_state == FB_DATA) && fch_rvalid_i;
  assign fwd = fill_v && fb_line == pc[31:LO] && fb_beat == pc[LO-1:2];
  assign fch_req_o = (fb_state == FB_REQ);
  assign fch_addr_o = {fb_line, {LO{1'b0}}};

  // fetch sequencer: demand miss first, else prefetch next line
  always_comb begin
    next_fb_state = fb_state;
    next_fb_line = fb_line;
    next_fb_beat = fb_beat;
    unique case (fb_state)
      FB_IDLE: begin
        if (!hit) begin
          next_fb_line = pc[31:LO];
          next_fb_state = FB_REQ;
        end else if (!pf_hit) begin
          next_fb_line = pc[31:LO] + 1'b1;
          next_fb_state = FB_REQ;
        end
      end
      FB_REQ: begin
        if (fch_gnt_i) begin
          next_fb_beat = '0;
          next_fb_state = FB_DATA;
        end
      end
      FB_DATA: begin
        if (fch_rvalid_i) begin
          next_fb_beat = fb_beat + 1'b1;
          if (fb_beat == sfp_pkg::LAST_BEAT) next_fb_state = FB_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      fb_state <= FB_IDLE;
      fb_line <= '0;
      fb_beat <= '0;
    end else begin
      fb_state <= next_fb_state;
      fb_line <= next_fb_line;
      fb_beat <= next_fb_beat;
    end
  end

  // decode, hazard check and operand selection
  always_comb begin
    ins = hit ? c_word : fch_rdata_i;
    ins_ok = hit || fwd;
    d = sfp_decode(ins);
    a = opnd(d.rs1);
    b = d.lit ? {27'h0, d.rs2} : opnd(d.rs2);
    c = opnd(d.rd);
    ea = a + ((d.fmt == sfp_pkg::FMT_MEMA) ? d.imm : (b << d.scale));
    is_dm = (d.fmt == sfp_pkg::FMT_MEMA) || (d.fmt == sfp_pkg::FMT_MEMB)
            || d.op == sfp_pkg::OP_ATADD || d.op == sfp_pkg::OP_ATMOD;
    is_ld = d.op == sfp_pkg::OP_LD || d.op == sfp_pkg::OP_LDX
            || d.op == sfp_pkg::OP_ATADD || d.op == sfp_pkg::OP_ATMOD;
    use_rs2 = (d.fmt == sfp_pkg::FMT_REG && !d.lit) || d.fmt == sfp_pkg::FMT_MEMB;
    haz = (d.fmt != sfp_pkg::FMT_CTRL && d.op != sfp_pkg::OP_FLUSHREG
           && (sb[d.rd] || sb[d.rs1])) || (use_rs2 && sb[d.rs2]);
    haz = haz || ((d.op == sfp_pkg::OP_BE || d.op == sfp_pkg::OP_BNE) && w_cmp);
    dq_free = !dq_valid || dmem_ready_i;
    res_stall = (is_dm && !dq_free) || (is_ld && ld_cnt == sfp_pkg::MAX_LOADS);
    issue = (iss == ISS_RUN) && ins_ok && !haz && !res_stall;
    fl_reg = sfp_pkg::LOCAL_BASE | {1'b0, fl_idx};
  end

  // single-cycle ALU
  always_comb begin
    res = 32'h0;
    unique case (d.op)
      sfp_pkg::OP_MOV: res = b;
      sfp_pkg::OP_ADD: res = a + b;
      sfp_pkg::OP_SUB: res = a - b;
      sfp_pkg::OP_AND: res = a & b;
      sfp_pkg::OP_OR: res = a | b;
      sfp_pkg::OP_XOR: res = a ^ b;
      sfp_pkg::OP_SHL: res = a << b[4:0];
      sfp_pkg::OP_SHR: res = a >> b[4:0];
      default: res = 32'h0;
    endcase
  end

  // issue, scoreboard, memory request and write-back next state
  always_comb begin
    next_pc = pc;
    next_iss = iss;
    next_fl_idx = fl_idx;
    next_sb = sb;
    ld_inc = 1'b0;
    next_w_valid = 1'b0;
    next_w = w;
    next_w_cmp = 1'b0;
    next_w_eq = w_eq;
    next_cc = w_cmp ? w_eq : cc;
    next_dq_valid = dq_valid && !dmem_ready_i;
    next_dq = dq;
    if (drsp_valid_i) next_sb[drsp_i.tag] = 1'b0;
    if (issue) begin
      next_pc = pc + sfp_pkg::PC_STEP;
      unique case (d.fmt)
        sfp_pkg::FMT_CTRL: begin
          if (d.op == sfp_pkg::OP_B || (d.op == sfp_pkg::OP_BE && cc)
              || (d.op == sfp_pkg::OP_BNE && !cc)) next_pc = pc + d.imm;
        end
        sfp_pkg::FMT_COBR: begin
          if ((d.op == sfp_pkg::OP_CMPBE && c == a)
              || (d.op == sfp_pkg::OP_CMPBNE && c != a)) next_pc = pc + d.imm;
        end
        sfp_pkg::FMT_REG: begin
          if (d.op == sfp_pkg::OP_FLUSHREG) begin
            next_iss = ISS_FLUSH;
            next_fl_idx = 4'h0;
          end else if (is_dm) begin
            next_dq_valid = 1'b1;
            next_dq.op = (d.op == sfp_pkg::OP_ATADD) ? sfp_pkg::DOP_ATADD : sfp_pkg::DOP_ATMOD;
            next_dq.addr = a;
            next_dq.wdata = b;
            next_dq.mask = c;
            next_dq.tag = d.rd;
            next_sb[d.rd] = 1'b1;
            ld_inc = 1'b1;
          end else if (d.op == sfp_pkg::OP_CMP) begin
            next_w_cmp = 1'b1;
            next_w_eq = (a == b);
          end else if (d.op >= sfp_pkg::OP_MOV && d.op <= sfp_pkg::OP_SHR) begin
            next_w_valid = 1'b1;
            next_w.dst = d.rd;
            next_w.data = res;
          end
        end
        sfp_pkg::FMT_MEMA, sfp_pkg::FMT_MEMB: begin
          next_dq_valid = 1'b1;
          next_dq.op = is_ld ? sfp_pkg::DOP_LOAD : sfp_pkg::DOP_STORE;
          next_dq.addr = ea;
          next_dq.wdata = c;
          next_dq.mask = '1;
          next_dq.tag = d.rd;
          if (is_ld) begin
            next_sb[d.rd] = 1'b1;
            ld_inc = 1'b1;
          end
        end
        default: next_pc = pc;
      endcase
    end
    // spill the sixteen local registers to the frame pointer area
    if (iss == ISS_FLUSH && !sb[fl_reg] && !sb[sfp_pkg::FP_REG] && dq_free) begin
      next_dq_valid = 1'b1;
      next_dq.op = sfp_pkg::DOP_STORE;
      next_dq.addr = opnd(sfp_pkg::FP_REG) + {26'h0, fl_idx, 2'h0};
      next_dq.wdata = opnd(fl_reg);
      next_dq.mask = '1;
      next_dq.tag = fl_reg;
      next_fl_idx = fl_idx + 1'b1;
      if (fl_idx == sfp_pkg::LAST_LOCAL) next_iss = ISS_RUN;
    end
    next_ld_cnt = ld_cnt + {1'b0, ld_inc} - {1'b0, drsp_valid_i};
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pc <= sfp_pkg::RESET_PC;
      iss <= ISS_RUN;
      fl_idx <= 4'h0;
      sb <= '0;
      ld_cnt <= 2'h0;
      cc <= 1'b0;
      w_valid <= 1'b0;
      w <= '0;
      w_cmp <= 1'b0;
      w_eq <= 1'b0;
      dq_valid <= 1'b0;
      dq <= '0;
    end else begin
      pc <= next_pc;
      iss <= next_iss;
      fl_idx <= next_fl_idx;
      sb <= next_sb;
      ld_cnt <= next_ld_cnt;
      cc <= next_cc;
      w_valid <= next_w_valid;
      w <= next_w;
      w_cmp <= next_w_cmp;
      w_eq <= next_w_eq;
      dq_valid <= next_dq_valid;
      dq <= next_dq;
    end
  end

  // register file: write-back port and load-return port
  always_ff @(posedge mclk_i) begin
    if (w_valid) rf[w.dst] <= w.data;
    if (drsp_valid_i) rf[drsp_i.tag] <= drsp_i.data;
  end

  assign dmem_valid_o = dq_valid;
  assign dmem_req_o = dq;
  assign wb_valid_o = w_valid;
  assign wb_o = w;
  assign pc_o = pc;
endmodule

// file: rtl/sfp_icache.sv
// direct-mapped instruction cache with burst fill and two lookup ports
module sfp_icache #(
  parameter int LINES = sfp_pkg::CACHE_LINES,
  parameter int WORDS = sfp_pkg::LINE_WORDS
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [31:0] rd_addr_i,
  output logic rd_hit_o,
  output logic [31:0] rd_word_o,
  input wire logic [31:0] probe_addr_i,
  output logic probe_hit_o,
  input wire logic fill_valid_i,
  input wire logic [31:0] fill_addr_i,
  input wire logic [31:0] fill_data_i,
  input wire logic fill_first_i,
  input wire logic fill_last_i
);
  localparam int OW = $clog2(WORDS);
  localparam int IW = $clog2(LINES);
  localparam int LB = 2 + OW;
  localparam int TW = 32 - LB - IW;

  logic [31:0] mem [LINES*WORDS];
  logic [TW-1:0] tags [LINES];
  logic [LINES-1:0] vld;
  logic [LINES-1:0] next_vld;

  function automatic logic [IW-1:0] idx_of(input logic [31:0] a);
    return a[LB +: IW];
  endfunction

  function automatic logic [TW-1:0] tag_of(input logic [31:0] a);
    return a[31 -: TW];
  endfunction

  // lookups: fetch address and prefetch probe
  assign rd_hit_o = vld[idx_of(rd_addr_i)] && (tags[idx_of(rd_addr_i)] == tag_of(rd_addr_i));
  assign rd_word_o = mem[rd_addr_i[2 +: OW+IW]];
  assign probe_hit_o = vld[idx_of(probe_addr_i)]
                       && (tags[idx_of(probe_addr_i)] == tag_of(probe_addr_i));

  // line goes invalid on its first beat, valid after the last
  always_comb begin
    next_vld = vld;
    if (fill_valid_i && fill_first_i) next_vld[idx_of(fill_addr_i)] = 1'b0;
    if (fill_valid_i && fill_last_i) next_vld[idx_of(fill_addr_i)] = 1'b1;
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) vld <= '0;
    else vld <= next_vld;
  end

  // burst words land straight in the array
  always_ff @(posedge mclk_i) begin
    if (fill_valid_i) begin
      mem[fill_addr_i[2 +: OW+IW]] <= fill_data_i;
      if (fill_first_i) tags[idx_of(fill_addr_i)] <= tag_of(fill_addr_i);
    end
  end
endmodule

// file: shared/sfp_pkg.sv
// shared constants, types and decode helpers for the scoreboarded fetch pipeline
package sfp_pkg;
  // core widths and sizes
  localparam int XLEN = 32;
  localparam int NREG = 32;
  localparam int LINE_WORDS = 4;
  localparam int BEAT_W = 2;
  localparam int LINE_OFS = 4;
  localparam int CACHE_BYTES = 512;
  localparam int CACHE_LINES = CACHE_BYTES / (4 * LINE_WORDS);
  localparam logic [1:0] MAX_LOADS = 2'h3;
  localparam logic [1:0] LAST_BEAT = 2'h3;
  localparam logic [4:0] FP_REG = 5'h0F;
  localparam logic [4:0] LOCAL_BASE = 5'h10;
  localparam logic [3:0] LAST_LOCAL = 4'hF;
  localparam logic [31:0] RESET_PC = 32'h00000000;
  localparam logic [31:0] PC_STEP = 32'h00000004;

  // instruction field positions
  localparam int OP_POS = 24;
  localparam int RD_POS = 19;
  localparam int RS1_POS = 14;
  localparam int LIT_POS = 13;
  localparam int SCALE_POS = 5;

  // control format opcodes
  localparam logic [7:0] OP_B = 8'h08;
  localparam logic [7:0] OP_BE = 8'h12;
  localparam logic [7:0] OP_BNE = 8'h15;
  // compare-and-branch format opcodes
  localparam logic [7:0] OP_CMPBE = 8'h32;
  localparam logic [7:0] OP_CMPBNE = 8'h35;
  // register format opcodes
  localparam logic [7:0] OP_MOV = 8'h40;
  localparam logic [7:0] OP_ADD = 8'h41;
  localparam logic [7:0] OP_SUB = 8'h42;
  localparam logic [7:0] OP_AND = 8'h43;
  localparam logic [7:0] OP_OR = 8'h44;
  localparam logic [7:0] OP_XOR = 8'h45;
  localparam logic [7:0] OP_SHL = 8'h46;
  localparam logic [7:0] OP_SHR = 8'h47;
  localparam logic [7:0] OP_CMP = 8'h48;
  localparam logic [7:0] OP_FLUSHREG = 8'h60;
  localparam logic [7:0] OP_ATADD = 8'h61;
  localparam logic [7:0] OP_ATMOD = 8'h62;
  // memory formats: offset and indexed
  localparam logic [7:0] OP_LD = 8'h80;
  localparam logic [7:0] OP_ST = 8'h82;
  localparam logic [7:0] OP_LDX = 8'h90;
  localparam logic [7:0] OP_STX = 8'h92;

  typedef enum logic [2:0] {FMT_CTRL, FMT_COBR, FMT_REG, FMT_MEMA, FMT_MEMB} sfp_fmt_type;
  typedef enum logic [1:0] {DOP_LOAD, DOP_STORE, DOP_ATADD, DOP_ATMOD} sfp_dop_type;

  typedef struct packed {
    sfp_dop_type op;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] mask;
    logic [4:0] tag;
  } sfp_dreq_type;

  typedef struct packed {
    logic [4:0] tag;
    logic [31:0] data;
  } sfp_drsp_type;

  typedef struct packed {
    logic [4:0] dst;
    logic [31:0] data;
  } sfp_wb_type;

  typedef struct packed {
    sfp_fmt_type fmt;
    logic [7:0] op;
    logic [4:0] rd;
    logic [4:0] rs1;
    logic [4:0] rs2;
    logic lit;
    logic [2:0] scale;
    logic [31:0] imm;
  } sfp_dec_type;

  // each opcode belongs to exactly one format
  function automatic sfp_fmt_type sfp_fmt(input logic [7:0] op);
    if (op[7:5] == 3'h0) return FMT_CTRL;
    else if (op[7:5] == 3'h1) return FMT_COBR;
    else if (!op[7]) return FMT_REG;
    else if (op[7:4] == 4'h8) return FMT_MEMA;
    else return FMT_MEMB;
  endfunction
endpackage

// file: verif/sfp_core_properties.sv
// port-level checks for the core: fetch bursts, data requests, scoreboard
module sfp_core_properties (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic fch_req_o,
  input wire logic [31:0] fch_addr_o,
  input wire logic fch_gnt_i,
  input wire logic fch_rvalid_i,
  input wire logic dmem_valid_o,
  input wire sfp_pkg::sfp_dreq_type dmem_req_o,
  input wire logic dmem_ready_i,
  input wire logic drsp_valid_i,
  input wire sfp_pkg::sfp_drsp_type drsp_i,
  input wire logic wb_valid_o,
  input wire sfp_pkg::sfp_wb_type wb_o,
  input wire logic [31:0] pc_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] busy, next_busy;
  logic [2:0] cnt, next_cnt, left, next_left;
  logic take_ld;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // a taken load or atomic owes a tagged return
  assign take_ld = dmem_valid_o && dmem_ready_i && dmem_req_o.op != sfp_pkg::DOP_STORE;
  // busy registers, returns owed and fetch beats owed
  always_comb begin
    next_busy = busy;
    if (drsp_valid_i) next_busy[drsp_i.tag] = 1'b0;
    if (take_ld) next_busy[dmem_req_o.tag] = 1'b1;
    next_cnt = cnt + {2'h0, take_ld} - {2'h0, drsp_valid_i};
    next_left = left;
    if (fch_req_o && fch_gnt_i) next_left = 3'h4;
    else if (fch_rvalid_i && left != 3'h0) next_left = left - 3'h1;
  end
  // helper state
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      busy <= 32'h0;
      cnt <= 3'h0;
      left <= 3'h0;
    end else begin
      busy <= next_busy;
      cnt <= next_cnt;
      left <= next_left;
    end
  end
  chk_reset_quiet: assert property ($rose(rst_n_i) |-> !fch_req_o && !dmem_valid_o
    && !wb_valid_o && pc_o == 32'h0) else $error("outputs active after reset");
  chk_first_fetch: assert property ($rose(rst_n_i) |-> ##[1:2] fch_req_o
    && fch_addr_o == 32'h0) else $error("no fetch of line zero after reset");
  chk_line_align: assert property (fch_req_o |-> fch_addr_o[3:0] == 4'h0)
    else $error("fetch address not on a line");
  chk_req_hold: assert property (fch_req_o && !fch_gnt_i |=> fch_req_o
    && $stable(fch_addr_o)) else $error("fetch request dropped before grant");
  chk_fetch_gap: assert property (fch_req_o && fch_gnt_i |=> !fch_req_o [*4])
    else $error("fetch request inside a burst");
  chk_burst_addr: assert property (left != 3'h0 |-> !fch_req_o && $stable(fch_addr_o))
    else $error("burst address moved or new request");
  chk_dreq_hold: assert property (dmem_valid_o && !dmem_ready_i |=> dmem_valid_o
    && $stable(dmem_req_o)) else $error("data request changed before taken");
  chk_load_limit: assert property (cnt <= 3'h3)
    else $error("more than three loads outstanding");
  chk_busy_ref: assert property (dmem_valid_o |-> !busy[dmem_req_o.tag])
    else $error("request uses a register still loading");
  chk_wb_free: assert property (wb_valid_o |-> !busy[wb_o.dst])
    else $error("write-back to a register still loading");
  cover property (fch_req_o && fch_gnt_i);
  cover property (cnt == 3'h3);
  cover property (dmem_valid_o && dmem_req_o.op == sfp_pkg::DOP_ATADD);
  cover property (dmem_valid_o && !dmem_ready_i);
endmodule

// file: verif/sfp_mem_model.sv
// behavioural memory: line bursts for fetch, tagged returns for data
module sfp_mem_model (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  input wire logic fch_req_i,
  input wire logic [31:0] fch_addr_i,
  output logic fch_gnt_o,
  output logic fch_rvalid_o,
  output logic [31:0] fch_rdata_o,
  input wire logic dmem_valid_i,
  input wire sfp_pkg::sfp_dreq_type dmem_req_i,
  output logic dmem_ready_o,
  output logic drsp_valid_o,
  output sfp_pkg::sfp_drsp_type drsp_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] imem [0:127];
  logic [31:0] dmem [0:63];
  sfp_pkg::sfp_drsp_type pend [$];
  logic [31:0] old;
  logic [5:0] ix;
  logic open, tick;
  int beat, lat;
  // quiet outputs at time zero
  initial begin
    {fch_gnt_o, fch_rvalid_o, dmem_ready_o, drsp_valid_o} = 4'h0;
    fch_rdata_o = 32'h0;
    drsp_o = '0;
    {open, tick, beat, lat} = '0;
  end
  // slow mode stalls every other cycle; idle data lines keep toggling
  always @(posedge mclk_i) begin
    tick = ~tick;
    {fch_gnt_o, fch_rvalid_o, drsp_valid_o} <= 3'h0;
    fch_rdata_o <= ~fch_rdata_o;
    drsp_o.data <= ~drsp_o.data;
    dmem_ready_o <= !(slow_i && tick);
    if (!rst_n_i) begin
      open = 1'b0;
      lat = 0;
      pend.delete();
    end else begin
      if (fch_req_i && !open) begin
        fch_gnt_o <= 1'b1;
        open = 1'b1;
        beat = 0;
      end else if (open && !(slow_i && tick)) begin
        fch_rvalid_o <= 1'b1;
        fch_rdata_o <= imem[fch_addr_i[8:2] + beat[6:0]];
        beat++;
        open = beat < 4;
      end
      if (dmem_valid_i && dmem_ready_o) begin
        ix = dmem_req_i.addr[7:2];
        old = dmem[ix];
        case (dmem_req_i.op)
          sfp_pkg::DOP_STORE: dmem[ix] = dmem_req_i.wdata;
          sfp_pkg::DOP_ATADD: dmem[ix] = old + dmem_req_i.wdata;
          default: dmem[ix] = (old & ~dmem_req_i.mask) | (dmem_req_i.wdata & dmem_req_i.mask);
        endcase
        if (dmem_req_i.op != sfp_pkg::DOP_STORE) pend.push_back('{dmem_req_i.tag, old});
      end
      if (pend.size() > 0) begin
        lat++;
        if (lat >= (slow_i ? 12 : 1)) begin
          drsp_valid_o <= 1'b1;
          drsp_o <= pend.pop_front();
          lat = 0;
        end
      end
    end
  end
endmodule

// file: verif/test_sfp_core.sv
// self-checking bench for the core against a behavioural memory
module test_sfp_core;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i, rst_n_i, slow, fch_req_o, fch_gnt_i, fch_rvalid_i;
  logic dmem_valid_o, dmem_ready_i, drsp_valid_i, wb_valid_o;
  logic [31:0] fch_addr_o, fch_rdata_i, pc_o;
  sfp_pkg::sfp_dreq_type dmem_req_o;
  sfp_pkg::sfp_drsp_type drsp_i;
  sfp_pkg::sfp_wb_type wb_o;
  sfp_pkg::sfp_dreq_type dq [$];
  sfp_pkg::sfp_wb_type wq [$];
  logic [31:0] fq [$];
  int wt [$];
  int miscompares, checked, cyc, t_beat, t_rsp, t7, outs, outs_max, npf;
  logic [31:0] pc_w0;
  sfp_core u_sfp_core (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .fch_req_o(fch_req_o),
    .fch_addr_o(fch_addr_o), .fch_gnt_i(fch_gnt_i), .fch_rvalid_i(fch_rvalid_i),
    .fch_rdata_i(fch_rdata_i), .dmem_valid_o(dmem_valid_o), .dmem_req_o(dmem_req_o),
    .dmem_ready_i(dmem_ready_i), .drsp_valid_i(drsp_valid_i), .drsp_i(drsp_i),
    .wb_valid_o(wb_valid_o), .wb_o(wb_o), .pc_o(pc_o));
  sfp_mem_model u_sfp_mem_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .slow_i(slow),
    .fch_req_i(fch_req_o), .fch_addr_i(fch_addr_o), .fch_gnt_o(fch_gnt_i),
    .fch_rvalid_o(fch_rvalid_i), .fch_rdata_o(fch_rdata_i), .dmem_valid_i(dmem_valid_o),
    .dmem_req_i(dmem_req_o), .dmem_ready_o(dmem_ready_i), .drsp_valid_o(drsp_valid_i),
    .drsp_o(drsp_i));
  // clock
  initial begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  // record what the core hands out and when
  always @(posedge mclk_i) begin
    cyc++;
    if (dmem_valid_o && dmem_ready_i) dq.push_back(dmem_req_o);
    if (wb_valid_o && wq.size() == 0) pc_w0 = pc_o;
    if (wb_valid_o) begin
      wq.push_back(wb_o);
      wt.push_back(cyc);
    end
    if (fch_req_o && fch_gnt_i) fq.push_back(fch_addr_o);
    // a grant for the line after the one at decode is a prefetch
    if (fch_req_o && fch_gnt_i && fch_addr_o[31:4] == pc_o[31:4] + 28'h1) npf++;
    if (fch_rvalid_i && t_beat == 0) t_beat = cyc;
    if (drsp_valid_i && t_rsp == 0) t_rsp = cyc;
    outs += int'(dmem_valid_o && dmem_ready_i && dmem_req_o.op != sfp_pkg::DOP_STORE);
    outs -= int'(drsp_valid_i);
    if (outs > outs_max) outs_max = outs;
  end
  task automatic chk(input bit ok, input string msg);
    checked++;
    if (!ok) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask
  function automatic logic [31:0] enc(logic [7:0] op, int rd, int rs1, logic lit, int low);
    return {op, 5'(rd), 5'(rs1), lit, 13'(low)};
  endfunction
  // reset, load the program, then let it run
  task automatic run(input logic s);
    int i;
    rst_n_i <= 1'b0;
    slow <= s;
    repeat (2) @(posedge mclk_i);
    for (i = 0; i < 128; i++) u_sfp_mem_model.imem[i] = enc(sfp_pkg::OP_MOV, 0, 0, 1, 0);
    for (i = 0; i < 64; i++) u_sfp_mem_model.dmem[i] = 32'h12340000 | 32'(i);
    u_sfp_mem_model.imem[1] = enc(sfp_pkg::OP_MOV, 2, 0, 1, 5);
    for (i = 0; i < 3; i++) begin
      u_sfp_mem_model.imem[3 + i] = enc(sfp_pkg::OP_LD, 4 + i, 1, 0, 64 + 4 * i);
    end
    u_sfp_mem_model.imem[6] = enc(sfp_pkg::OP_ADD, 7, 2, 1, 3);
    u_sfp_mem_model.imem[7] = enc(sfp_pkg::OP_LD, 9, 1, 0, 76);
    u_sfp_mem_model.imem[8] = enc(sfp_pkg::OP_ADD, 8, 4, 0, 5);
    u_sfp_mem_model.imem[9] = enc(sfp_pkg::OP_SUB, 10, 8, 1, 5);
    u_sfp_mem_model.imem[10] = enc(sfp_pkg::OP_ST, 10, 1, 0, 80);
    u_sfp_mem_model.imem[11] = enc(sfp_pkg::OP_ATADD, 11, 1, 1, 2);
    u_sfp_mem_model.imem[12] = enc(sfp_pkg::OP_FLUSHREG, 0, 0, 0, 0);
    u_sfp_mem_model.imem[0] = enc(sfp_pkg::OP_MOV, 1, 0, 1, 0);
    u_sfp_mem_model.imem[2] = enc(sfp_pkg::OP_MOV, 15, 0, 1, 0);
    // compare then branch on it, skipping one move; then an indexed store
    u_sfp_mem_model.imem[13] = enc(sfp_pkg::OP_CMP, 0, 2, 1, 5);
    u_sfp_mem_model.imem[14] = enc(sfp_pkg::OP_BE, 0, 0, 0, 2);
    u_sfp_mem_model.imem[15] = enc(sfp_pkg::OP_MOV, 12, 0, 1, 1);
    u_sfp_mem_model.imem[16] = enc(sfp_pkg::OP_MOV, 12, 0, 1, 2);
    u_sfp_mem_model.imem[17] = enc(sfp_pkg::OP_STX, 2, 1, 0, 13'h042);
    dq.delete();
    wq.delete();
    wt.delete();
    fq.delete();
    pc_w0 = '1;
    {t_beat, t_rsp, outs, outs_max, npf} = '0;
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (400) @(posedge mclk_i);
  endtask
  // results, request order and operands of the program
  task automatic check_prog();
    logic [31:0] v [32];
    int t [32];
    int i;
    sfp_pkg::sfp_dop_type eo;
    logic [31:0] ea;
    for (i = wq.size() - 1; i >= 0; i--) begin
      v[wq[i].dst] = wq[i].data;
      t[wq[i].dst] = wt[i];
    end
    t7 = t[7];
    chk(v[7] === 32'h00000008, "unrelated add");
    chk(v[8] === 32'h24680021, "sum of loaded values");
    chk(v[10] === 32'h2468001C, "dependent sub");
    chk(v[12] === 32'h00000002, "branch on compare result");
    chk(pc_w0 === 32'h00000004, "pc after first instruction");
    chk(dq.size() >= 23, "too few memory requests");
    chk(dq[22].addr === 32'h00000014 && dq[22].wdata === 32'h00000005, "indexed store");
    for (i = 0; i < 22; i++) begin
      eo = i < 4 ? sfp_pkg::DOP_LOAD : i == 5 ? sfp_pkg::DOP_ATADD : sfp_pkg::DOP_STORE;
      ea = i < 4 ? 32'h40 + 32'(4 * i) : i == 4 ? 32'h50 : i == 5 ? 32'h0 : 32'(4 * (i - 6));
      chk(dq[i].op === eo && dq[i].addr === ea, "request kind or address");
    end
    chk(dq[4].wdata === 32'h2468001C, "stored value");
    chk(dq[5].wdata === 32'h00000002, "atomic operand");
  endtask
  // prompt memory: first word decoded as it arrives, next line prefetched
  task automatic scen_prompt();
    run(1'b0);
    check_prog();
    chk(fq.size() > 1 && fq[0] === 32'h0 && fq[1] === 32'h10, "prefetch order");
    chk(wt.size() > 0 && wt[0] == t_beat + 1, "missed word not forwarded");
    chk(npf > 0, "no prefetch ahead of pc");
  endtask
  // slow memory: three loads pending while unrelated work completes
  task automatic scen_slow();
    run(1'b1);
    check_prog();
    chk(outs_max == 3, "pending load count");
    chk(t7 > 0 && t7 < t_rsp, "no overlap with loads");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (3000) @(posedge mclk_i);
    miscompares++;
    give_verdict();
  end
  initial begin
    rst_n_i = 1'b0;
    slow = 1'b0;
    {miscompares, checked, cyc} = '0;
    scen_prompt();
    scen_slow();
    give_verdict();
  end
endmodule
bind sfp_core sfp_core_properties u_sfp_core_properties (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .fch_req_o(fch_req_o), .fch_addr_o(fch_addr_o), .fch_gnt_i(fch_gnt_i),
  .fch_rvalid_i(fch_rvalid_i), .dmem_valid_o(dmem_valid_o), .dmem_req_o(dmem_req_o),
  .dmem_ready_i(dmem_ready_i), .drsp_valid_i(drsp_valid_i), .drsp_i(drsp_i),
  .wb_valid_o(wb_valid_o), .wb_o(wb_o), .pc_o(pc_o));
